// >>> pkg/carsp_pkg.sv
/*
  Shared constants for the centre-aligned read strobe port: byte layout,
  memory size, host clock divider phases and FIFO geometry.
  Assumes both ends and the interface import this package.
*/
package carsp_pkg;
  // Link widths
  localparam int DQ_W     = 8;   // Shared data lines
  localparam int ADDR_W   = 4;   // Byte address width
  localparam int LEN_W    = 4;   // Burst length minus one
  localparam int MEM_DEPTH = 16; // Bytes held by the device
  // Command byte layout
  localparam int CMD_READ_BIT = 7;
  // Device byte counter values
  localparam logic [1:0] CNT_CMD  = 2'h0;
  localparam logic [1:0] CNT_ADDR = 2'h1;
  localparam logic [1:0] CNT_DATA = 2'h2;
  // Host divider: bus clock high in phases 2 and 3
  localparam logic [1:0] PH_ACT   = 2'h0;
  localparam int PH_HIGH_BIT = 1;
  // Read data FIFO
  localparam int FIFO_DEPTH = 8;
  // Host sequencer states, one-hot
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_CMD  = 4'h2,
    H_ADDR = 4'h4,
    H_DATA = 4'h8
  } carsp_hst_t;
endpackage

// >>> pkg/carsp_if.sv
/*
  Link between the host and the memory end. Each shared pin carries a
  value and an enable per party; the wire level is resolved here.
  Assumes at most one party enables a pin at a time.
*/
`timescale 1ns/1ps
interface carsp_if;
  import carsp_pkg::*;
  // Clocks and select, driven by the host
  logic              cs_n;
  logic              bus_clk;
  logic              bus_clk_n;
  logic              shifted_strobe_clk;
  logic              shifted_strobe_clk_n;
  // Data lines, per driver
  logic [DQ_W-1:0]   dq_h;
  logic              dq_h_oe;
  logic [DQ_W-1:0]   dq_d;
  logic              dq_d_oe;
  // Strobe line, per driver
  logic              rw_data_strobe_h;
  logic              rw_data_strobe_h_oe;
  logic              rw_data_strobe_d;
  logic              rw_data_strobe_d_oe;
  // Resolved wire levels; an undriven line reads low
  logic [DQ_W-1:0]   dq;
  logic              rw_data_strobe;
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'h00);
  assign rw_data_strobe = rw_data_strobe_d_oe ? rw_data_strobe_d : (rw_data_strobe_h_oe & rw_data_strobe_h);
  // Memory end
  modport dev (
    input  cs_n, bus_clk, bus_clk_n, shifted_strobe_clk,
    input  shifted_strobe_clk_n, dq, rw_data_strobe,
    output dq_d, dq_d_oe, rw_data_strobe_d, rw_data_strobe_d_oe
  );
  // Controller end
  modport host (
    output cs_n, bus_clk, bus_clk_n, shifted_strobe_clk,
    output shifted_strobe_clk_n, dq_h, dq_h_oe, rw_data_strobe_h, rw_data_strobe_h_oe,
    input  dq, rw_data_strobe
  );
endinterface

// >>> design/carsp_dev.sv
/*
  Memory end of the centre-aligned read strobe port: command, address
  and data capture on the bus clock, a small byte store, and a strobe
  toggled by the phase shifted clock during read data.
  Assumes the host keeps its own rules: clocks stop between frames and
  select returns high between transactions.
*/
// Functional notes
// R1: Read strobe edges come from shifted clock.
// R2: Host shifts strobe clock ninety degrees normally.
// R3: Device ignores shifted clock during writes.
// R4: Host parks shifted clocks static during writes.
// R5: Single-ended mode: host drives complement low.
// R6: Differential mode uses both shifted clock phases. The device clocks its strobe on the true phase only.
// R7: Select fall starts, select rise ends transaction.
// R8: Transfers referenced to bus clock crossing.
// R9: No free-running bus clock needed.
// R10: Read bytes aligned to shifted-clock strobe edges.
// R11: Host drives strobe as write byte mask.
// R12: Strobe flags extra latency at transaction start.
// R13: Reset low returns device to idle.
// R14: Reset low releases strobe and data lines.
// R15: Command, address, data share eight lines.
// R16: Host starts with clock low, select between.
// R17: Device drives strobe through read data.
// R18: Host picks shift between forty and 140.
// R19: Strobe released whenever select is high.
`timescale 1ns/1ps
module carsp_dev
  import carsp_pkg::*;
(
  // Link side
  carsp_if.dev                     lnk,
  // Hardware reset pin
  input  wire logic                i_rst_n,
  // User side: latency flag and write capture
  input  wire logic                i_extra_latency,
  output logic                     o_wr_valid,
  output logic [ADDR_W-1:0]        o_wr_addr,
  output logic [DQ_W-1:0]          o_wr_data
);
  import carsp_pkg::*;

  // Bus clock state; strobe flop on shifted clock
  logic [1:0]        cnt_r;       // Bytes seen this frame, saturating
  logic              is_read_r;   // Command said read
  logic [ADDR_W-1:0] addr_r;      // Running byte address
  logic [DQ_W-1:0]   dq_out_r;    // Read byte on the lines
  logic              dq_oe_r;     // Read data phase under way
  logic              strobe_t_r;  // Strobe level, shifted clock domain
  logic              wr_valid_r;  // Write capture pulse
  logic [ADDR_W-1:0] wr_addr_r;   // Write capture address
  logic [DQ_W-1:0]   wr_data_r;   // Write capture byte
  logic [DQ_W-1:0]   mem [MEM_DEPTH];  // Byte store
  logic              ca_phase;    // Command or address byte pending
  logic              in_frame;    // Select low and reset released
  logic              rd_take;     // Bus clock edge in read data
  logic              wr_take;     // Bus clock edge in write data

  // One byte per rising bus clock edge:
  // command, address, then data bytes.
  // Falling edges are unused; half the peak rate
  // buys a single clock domain for the store.
  // Frame and phase decode
  assign in_frame = ~lnk.cs_n & i_rst_n; // R7
  assign ca_phase = (cnt_r != CNT_DATA);
  // Data phase split by direction
  assign rd_take  = (cnt_r == CNT_DATA) & is_read_r;
  assign wr_take  = (cnt_r == CNT_DATA) & ~is_read_r;

  // Byte counter; select high or reset pin aborts the frame at once.
  // Async clear is needed because the bus clock stops with the frame.
  always_ff @(posedge lnk.bus_clk or negedge i_rst_n or
              posedge lnk.cs_n) begin
    // Pin first, then select
    if (!i_rst_n) begin
      cnt_r <= CNT_CMD; // R13
    end else if (lnk.cs_n) begin
      // Deselected: restart at command
      cnt_r <= CNT_CMD; // R7
    end else if (cnt_r != CNT_DATA) begin
      // Only rising bus clock edges move the frame on
      cnt_r <= cnt_r + 2'h1; // R8 R9
    end
  end

  // Command byte: direction only, taken at the first edge
  // Kept until the next command
  always_ff @(posedge lnk.bus_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Default is write
      is_read_r <= 1'b0;
    end else if (in_frame && cnt_r == CNT_CMD) begin
      // Top bit set means read
      is_read_r <= lnk.dq[CMD_READ_BIT]; // R15
    end
  end

  // Address: loaded at the second edge, then advanced per data byte
  // Same order for read and write
  always_ff @(posedge lnk.bus_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_r <= '0;
    end else if (in_frame && cnt_r == CNT_ADDR) begin
      // High address bits unused
      addr_r <= lnk.dq[ADDR_W-1:0]; // R15
    end else if (in_frame && (rd_take || wr_take)) begin
      // Wraps inside the small store
      addr_r <= addr_r + 4'h1;
    end
  end

  // Read data out; the first byte appears one edge after the address,
  // leaving the host a full clock to release the lines.
  // Data and enable clear together
  always_ff @(posedge lnk.bus_clk or negedge i_rst_n or
              posedge lnk.cs_n) begin
    if (!i_rst_n) begin
      dq_out_r <= 8'h00; // R14
      dq_oe_r  <= 1'b0; // R14
    end else if (lnk.cs_n) begin
      // Frame over, no edge needed
      dq_out_r <= 8'h00;
      dq_oe_r  <= 1'b0;
    end else if (rd_take) begin
      // One byte per rise
      dq_out_r <= mem[addr_r]; // R15
      dq_oe_r  <= 1'b1; // R17
    end
  end

  // Byte store write; a high strobe masks the byte
  // Not reset; contents outlive the pin
  always_ff @(posedge lnk.bus_clk) begin
    if (in_frame && wr_take && !lnk.rw_data_strobe) begin
      mem[addr_r] <= lnk.dq; // R11
    end
  end

  // Capture report for the user, one pulse per unmasked byte
  always_ff @(posedge lnk.bus_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Reset pin clears the report
      wr_valid_r <= 1'b0;
      wr_addr_r  <= '0;
      wr_data_r  <= 8'h00;
    end else begin
      // Held while the clock stops
      wr_valid_r <= in_frame & wr_take & ~lnk.rw_data_strobe; // R11
      // Kept for masked bytes too
      if (in_frame && wr_take) begin
        wr_addr_r <= addr_r;
        wr_data_r <= lnk.dq;
      end
    end
  end

  // Strobe generator on the shifted clock. Its first edge after the
  // first read byte lands a quarter bus clock into the byte, so each byte gets one transition.
  // Only the true phase is used; in differential mode the complement
  // is its mirror and carries nothing extra. Select clears it, so no
  // value crosses in from the bus clock domain.
  always_ff @(posedge lnk.shifted_strobe_clk or negedge i_rst_n or
              posedge lnk.cs_n) begin
    if (!i_rst_n) begin
      strobe_t_r <= 1'b0;
    end else if (lnk.cs_n) begin
      // Each frame starts low
      strobe_t_r <= 1'b0;
    end else begin
      // Phase set by the host alone
      strobe_t_r <= ~strobe_t_r; // R1 R6 R10
    end
  end

  // Strobe line: latency flag during command and address, shifted
  // strobe during read data, released in write data so the host can
  // mask. The shifted clock is never looked at in writes.
  // Combinational so release follows select
  always_comb begin
    lnk.rw_data_strobe_d_oe = 1'b0;
    lnk.rw_data_strobe_d    = 1'b0;
    if (in_frame && ca_phase) begin
      // Latency flag out
      lnk.rw_data_strobe_d_oe = 1'b1; // R12
      lnk.rw_data_strobe_d    = i_extra_latency; // R12
    end else if (in_frame && dq_oe_r) begin
      // Read strobe out
      lnk.rw_data_strobe_d_oe = 1'b1; // R17
      lnk.rw_data_strobe_d    = strobe_t_r; // R10
    end else begin
      // Write data or no frame: hands off the line
      lnk.rw_data_strobe_d_oe = 1'b0; // R3 R19
    end
  end

  // Data lines only while selected, out of reset and reading
  // Release never waits on a clock
  assign lnk.dq_d_oe = dq_oe_r & in_frame; // R14
  assign lnk.dq_d    = dq_out_r;

  // User outputs
  // Registered on the bus clock
  assign o_wr_valid = wr_valid_r;
  assign o_wr_addr  = wr_addr_r;
  assign o_wr_data  = wr_data_r;

endmodule // carsp_dev

// >>> design/carsp_host.sv
/*
  Controller end of the port: divides its own clock by four into the bus
  clock, makes a quarter-period delayed copy as the shifted strobe clock,
  sequences command, address and data, and buffers read bytes in a FIFO.
  Assumes the memory answers reads one bus clock after the address.
*/
`timescale 1ns/1ps
module carsp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  // Fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];  // Storage
  logic [AW-1:0] wp_r;       // Write pointer
  logic [AW-1:0] rp_r;       // Read pointer
  logic [AW:0]   cnt_r;      // Fill level
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_r != (AW+1)'(D)); // Full stalls the source
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign push = i_in_valid & o_in_ready;
  assign pop  = o_out_valid & i_out_ready;

  // Pointers and level
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage
  always_ff @(posedge i_clock) begin
    if (push) mem_r[wp_r] <= i_in_data;
  end
endmodule // carsp_fifo

module carsp_host
  import carsp_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // Link side
  carsp_if.host                  lnk,
  // Mode
  input  wire logic              i_diff_mode,
  // Request
  input  wire logic              i_req_valid,
  output logic                   o_req_ready,
  input  wire logic              i_req_write,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  input  wire logic [LEN_W-1:0]  i_req_len,
  // Write bytes
  input  wire logic              i_wr_valid,
  output logic                   o_wr_ready,
  input  wire logic [DQ_W-1:0]   i_wr_data,
  input  wire logic              i_wr_mask,
  // Read bytes
  output logic                   o_rd_valid,
  input  wire logic              i_rd_ready,
  output logic [DQ_W-1:0]        o_rd_data,
  // Latency flag seen at frame start
  output logic                   o_lat_flag
);
  import carsp_pkg::*;

  carsp_hst_t       st_r;       // Sequencer state
  logic [1:0]       ph_r;       // Divider phase
  logic             wr_r;       // Frame is a write
  logic [LEN_W-1:0] left_r;     // Bytes still to move
  logic             cs_n_r;     // Select
  logic             ck_r;       // Bus clock
  logic             ck_n_r;     // Bus clock complement
  logic             psc_r;      // Shifted strobe clock
  logic             psc_n_r;    // Its complement
  logic             psc_run_r;  // Shifted clock enabled
  logic [DQ_W-1:0]  dq_r;       // Data out
  logic             dq_oe_r;    // Data enable
  logic             mask_r;     // Write mask level
  logic             mask_oe_r;  // Mask enable
  logic             lat_r;      // Captured latency flag
  logic             act;        // Host step point, bus clock low
  logic             stall;      // Hold the clock low
  logic             ending;     // Last step of a frame
  logic             adv;        // Divider moves on
  logic [1:0]       ph_nxt;
  logic             fifo_rdy;

  // Step once per bus clock, mid low phase
  assign act    = (ph_r == PH_ACT);
  assign stall  = (st_r == H_DATA) & (wr_r ? (left_r != '0) & ~i_wr_valid
                                           : ~fifo_rdy);
  assign ending = (st_r == H_DATA) & ~stall & (left_r == '0);
  // Clock only runs inside frames and pauses under back-pressure
  assign adv    = ~act | ((st_r == H_IDLE) ? i_req_valid : ~stall & ~ending);
  assign ph_nxt = adv ? ph_r + 2'h1 : ph_r;

  // Divider and derived clocks; shifted clock lags by a quarter period
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_r    <= PH_ACT;
      ck_r    <= 1'b0;
      ck_n_r  <= 1'b0;
      psc_r   <= 1'b0;
      psc_n_r <= 1'b0;
    end else begin
      ph_r    <= ph_nxt;
      ck_r    <= ph_nxt[PH_HIGH_BIT]; // R8 R16
      ck_n_r  <= i_diff_mode & ~ph_nxt[PH_HIGH_BIT]; // R8
      psc_r   <= psc_run_r & ck_r; // R2 R4
      psc_n_r <= psc_run_r & i_diff_mode & ~ck_r; // R4 R5 R6
    end
  end

  // Sequencer and pin drive
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r      <= H_IDLE;
      cs_n_r    <= 1'b1;
      wr_r      <= 1'b0;
      left_r    <= '0;
      dq_r      <= 8'h00;
      dq_oe_r   <= 1'b0;
      mask_r    <= 1'b0;
      mask_oe_r <= 1'b0;
      psc_run_r <= 1'b0;
      lat_r     <= 1'b0;
    end else if (act) begin
      case (st_r)
        H_IDLE: begin
          if (i_req_valid) begin
            cs_n_r  <= 1'b0; // R7 R16
            wr_r    <= i_req_write;
            left_r  <= i_req_len;
            dq_r    <= {~i_req_write, 7'h00}; // R15
            dq_oe_r <= 1'b1;
          end
        end
        H_CMD: begin
          dq_r  <= {4'h0, i_req_addr}; // R15
          lat_r <= lnk.rw_data_strobe;
        end
        H_ADDR: begin
          if (wr_r) begin
            dq_r      <= i_wr_data;
            mask_r    <= i_wr_mask; // R11
            mask_oe_r <= 1'b1; // R11
          end else begin
            dq_oe_r   <= 1'b0;
            psc_run_r <= 1'b1; // R18
          end
        end
        H_DATA: begin
          if (ending) begin
            cs_n_r    <= 1'b1; // R7
            dq_oe_r   <= 1'b0;
            mask_oe_r <= 1'b0;
            psc_run_r <= 1'b0;
          end else if (!stall) begin
            left_r <= left_r - 4'h1;
            if (wr_r) begin
              dq_r   <= i_wr_data;
              mask_r <= i_wr_mask; // R11
            end
          end
        end
        default: cs_n_r <= 1'b1;
      endcase
      // State moves only when the step is taken
      case (st_r)
        H_IDLE:  if (i_req_valid) st_r <= H_CMD;
        H_CMD:   st_r <= H_ADDR;
        H_ADDR:  st_r <= H_DATA;
        H_DATA:  if (ending) st_r <= H_IDLE;
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // Read bytes go to the FIFO; a full FIFO stops the bus clock
  carsp_fifo #(.W(DQ_W), .D(FIFO_DEPTH)) carsp_fifo_inst (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (act & (st_r == H_DATA) & ~wr_r),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (lnk.dq),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data)
  );

  // Pins and user handshakes
  assign lnk.cs_n                 = cs_n_r;
  assign lnk.bus_clk              = ck_r;
  assign lnk.bus_clk_n            = ck_n_r;
  assign lnk.shifted_strobe_clk   = psc_r;
  assign lnk.shifted_strobe_clk_n = psc_n_r;
  assign lnk.dq_h                 = dq_r;
  assign lnk.dq_h_oe              = dq_oe_r;
  assign lnk.rw_data_strobe_h               = mask_r;
  assign lnk.rw_data_strobe_h_oe            = mask_oe_r;
  assign o_req_ready = act & (st_r == H_IDLE);
  assign o_wr_ready  = act & ((st_r == H_ADDR) & wr_r |
                              (st_r == H_DATA) & wr_r & (left_r != '0));
  assign o_lat_flag  = lat_r;
endmodule // carsp_host

// >>> dv/carsp_asserts.sv
/*
  Concurrent checks on the link between host end and memory end.
  Assumes the link is made from i_clock by the host divider.
*/
`timescale 1ns/1ps
module carsp_asserts (
  // Host clock, reset and mode
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_diff_mode,
  // Link signals
  input  wire logic cs_n,
  input  wire logic bus_clk,
  input  wire logic bus_clk_n,
  input  wire logic shifted_strobe_clk,
  input  wire logic shifted_strobe_clk_n,
  input  wire logic dq_h_oe,
  input  wire logic dq_d_oe,
  input  wire logic rw_data_strobe_h_oe,
  input  wire logic rw_data_strobe_d_oe,
  input  wire logic rw_data_strobe
);
  // One domain: the host clock and its reset
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // Frame opens with clock low, complement high in differential mode, command driven
  sequence s_open;
    !bus_clk && (bus_clk_n || !i_diff_mode) && dq_h_oe;
  endsequence
  // Command byte clocked shortly after
  sequence s_cmd_edge;
    ##[1:4] $rose(bus_clk);
  endsequence
  property p_frame_start;
    $fell(cs_n) |-> s_open ##0 s_cmd_edge;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame did not open as expected");
  property p_frame_clock;
    $fell(cs_n) |-> !bus_clk && (bus_clk_n || !i_diff_mode);
  endproperty
  a_frame_clock: assert property (p_frame_clock)
    else $error("frame opened with clock in wrong state");

  // Latency flag driven early in every frame
  property p_lat_flag;
    $fell(cs_n) |-> ##[0:3] rw_data_strobe_d_oe;
  endproperty
  a_lat_flag: assert property (p_lat_flag)
    else $error("latency flag not driven at frame start");

  // Lines released once select has been high a cycle
  property p_idle_release;
    cs_n && $past(cs_n) |-> !rw_data_strobe_d_oe && !dq_d_oe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("device drives a line while deselected");

  // Each shifted clock rise moves the strobe
  property p_psc_edge;
    $rose(shifted_strobe_clk) && !cs_n |-> $changed(rw_data_strobe);
  endproperty
  a_psc_edge: assert property (p_psc_edge)
    else $error("strobe did not follow shifted clock");

  // Device owns the strobe while the shifted clock runs
  property p_read_drive;
    shifted_strobe_clk && !cs_n |-> rw_data_strobe_d_oe && !rw_data_strobe_h_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("strobe not driven by device in read data");

  // Shifted clocks parked low while the host masks writes
  property p_write_park;
    rw_data_strobe_h_oe |-> !shifted_strobe_clk && !shifted_strobe_clk_n;
  endproperty
  a_write_park: assert property (p_write_park)
    else $error("shifted clock moving during write");

  // Mask only inside a frame, never against the device
  property p_mask_dir;
    rw_data_strobe_h_oe |-> !rw_data_strobe_d_oe && !cs_n;
  endproperty
  a_mask_dir: assert property (p_mask_dir)
    else $error("strobe contention or mask outside frame");

  // Single-ended: complements held low, settled two cycles
  property p_se_low;
    !i_diff_mode && !$past(i_diff_mode, 2) |->
      !shifted_strobe_clk_n && !bus_clk_n;
  endproperty
  a_se_low: assert property (p_se_low)
    else $error("complement clock not low in single mode");

  // Differential: bus clock pair opposed, shifted pair never both high, inside a frame
  property p_diff_pair;
    i_diff_mode && !cs_n && !$past(cs_n) |->
      bus_clk_n != bus_clk && !(shifted_strobe_clk && shifted_strobe_clk_n);
  endproperty
  a_diff_pair: assert property (p_diff_pair)
    else $error("differential pair not complementary");
endmodule // carsp_asserts

// >>> dv/tb_center_aligned_read_strobe_port.sv
/*
  Self-checking bench: host and memory end joined by the link.
  Assumes the package, interface, both ends and checker compile first.
*/
`timescale 1ns/1ps
module tb_center_aligned_read_strobe_port;
  import carsp_pkg::*;
  // Clock, reset, modes
  logic              clk       = 1'b0;
  logic              rst_n     = 1'b0;
  logic              diff_mode = 1'b0;
  logic              extra_lat = 1'b0;
  // Host user side
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr  = 4'h0;
  logic [LEN_W-1:0]  req_len   = 4'h0;
  logic              wr_valid  = 1'b0;
  logic [DQ_W-1:0]   wr_data   = 8'h00;
  logic              wr_mask   = 1'b0;
  logic              rd_ready  = 1'b1;
  logic              req_ready, wr_ready, rd_valid, lat_flag, dv_valid;
  logic [DQ_W-1:0]   rd_data, dv_data, pv_data;
  logic [ADDR_W-1:0] dv_addr, pv_addr;
  logic              pv_valid  = 1'b0;
  // Scoreboard
  int                fail_count      = 0;
  int                samples_checked = 0;
  logic [DQ_W-1:0]   mem_m [MEM_DEPTH];
  logic [DQ_W-1:0]   rd_q [$];
  logic [11:0]       wr_q [$];
  logic [11:0]       exp_q [$];

  always #5 clk = ~clk;

  carsp_if carsp_if_inst ();
  carsp_dev carsp_dev_inst (.lnk(carsp_if_inst), .i_rst_n(rst_n),
    .i_extra_latency(extra_lat), .o_wr_valid(dv_valid),
    .o_wr_addr(dv_addr), .o_wr_data(dv_data));
  carsp_host carsp_host_inst (.i_clock(clk), .i_rst_n(rst_n),
    .lnk(carsp_if_inst), .i_diff_mode(diff_mode), .i_req_valid(req_valid),
    .o_req_ready(req_ready), .i_req_write(req_write), .i_req_addr(req_addr),
    .i_req_len(req_len), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready),
    .i_wr_data(wr_data), .i_wr_mask(wr_mask), .o_rd_valid(rd_valid),
    .i_rd_ready(rd_ready), .o_rd_data(rd_data), .o_lat_flag(lat_flag));
  carsp_asserts carsp_asserts_inst (.i_clock(clk), .i_rst_n(rst_n),
    .i_diff_mode(diff_mode), .cs_n(carsp_if_inst.cs_n),
    .bus_clk(carsp_if_inst.bus_clk), .bus_clk_n(carsp_if_inst.bus_clk_n),
    .shifted_strobe_clk(carsp_if_inst.shifted_strobe_clk),
    .shifted_strobe_clk_n(carsp_if_inst.shifted_strobe_clk_n),
    .dq_h_oe(carsp_if_inst.dq_h_oe), .dq_d_oe(carsp_if_inst.dq_d_oe),
    .rw_data_strobe_h_oe(carsp_if_inst.rw_data_strobe_h_oe), .rw_data_strobe_d_oe(carsp_if_inst.rw_data_strobe_d_oe),
    .rw_data_strobe(carsp_if_inst.rw_data_strobe));

  // Collect popped read bytes and each new captured write
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && rd_ready) rd_q.push_back(rd_data);
    if (dv_valid === 1'b1 && !(pv_valid && {pv_addr, pv_data} ==
        {dv_addr, dv_data})) wr_q.push_back({dv_addr, dv_data});
    pv_valid = dv_valid;
    pv_addr  = dv_addr;
    pv_data  = dv_data;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Wait for select high and the host ready, bounded
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(carsp_if_inst.cs_n && req_ready) && n < 400);
    check(16'(n < 400), 16'h0001);
  endtask

  // Hold the request until the edge that takes it
  task automatic do_req(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [LEN_W-1:0] l);
    int n;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_len   <= l;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!req_ready && n < 50);
    req_valid <= 1'b0;
    check(16'(n < 50), 16'h0001);
  endtask

  // Burst write; masked bytes must not be captured
  task automatic put_bytes(input logic [ADDR_W-1:0] a, input int cnt,
                           input logic [DQ_W-1:0] b, input logic [15:0] mk);
    int n;
    exp_q.delete();
    wr_q.delete();
    do_req(1'b1, a, LEN_W'(cnt - 1));
    for (int i = 0; i < cnt; i++) begin
      wr_valid <= 1'b1;
      wr_data  <= b + DQ_W'(i);
      wr_mask  <= mk[i];
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!wr_ready && n < 100);
      check(16'(n < 100), 16'h0001);
      if (!mk[i]) begin
        mem_m[a + ADDR_W'(i)] = b + DQ_W'(i);
        exp_q.push_back({a + ADDR_W'(i), b + DQ_W'(i)});
      end
    end
    wr_valid <= 1'b0;
    wait_idle();
    check(16'(wr_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) check(16'(wr_q[i]), 16'(exp_q[i]));
  endtask

  // Burst read, optionally stalling the drain side
  task automatic get_bytes(input logic [ADDR_W-1:0] a, input int cnt,
                           input int stall);
    int n;
    rd_q.delete();
    rd_ready <= (stall == 0);
    do_req(1'b0, a, LEN_W'(cnt - 1));
    if (stall > 0) begin
      repeat (stall) @(posedge clk);
      check(16'({carsp_if_inst.cs_n, rd_valid}), 16'h0001);
      rd_ready <= 1'b1;
    end
    n = 0;
    while (rd_q.size() < cnt && n < 400) begin
      @(posedge clk);
      n++;
    end
    wait_idle();
    check(16'(rd_q.size()), 16'(cnt));
    foreach (rd_q[i]) check(16'(rd_q[i]), 16'(mem_m[a + ADDR_W'(i)]));
  endtask

  // Full burst in, then read with the buffer held full
  task automatic t_fill_stall;
    put_bytes(4'h0, 16, 8'h30, 16'h0000);
    get_bytes(4'h0, 16, 150);
    $display("test fill_stall done");
  endtask

  // Wrapping burst with one masked byte
  task automatic t_mask_wrap;
    put_bytes(4'hE, 4, 8'hA0, 16'h0002);
    get_bytes(4'hE, 4, 0);
    $display("test mask_wrap done");
  endtask

  // Every clock mode against both latency flags
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      diff_mode <= m[1];
      extra_lat <= m[0];
      repeat (4) @(posedge clk);
      get_bytes(ADDR_W'(m), 1, 0);
      check(16'(lat_flag), 16'(m[0]));
    end
    diff_mode <= 1'b0;
    extra_lat <= 1'b0;
    $display("test modes done");
  endtask

  // Reset in mid read; lines released, then normal service
  task automatic t_reset_mid;
    do_req(1'b0, 4'h0, 4'hF);
    repeat (20) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check(16'({carsp_if_inst.dq_d_oe, carsp_if_inst.rw_data_strobe_d_oe,
               carsp_if_inst.cs_n}), 16'h0001);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    put_bytes(4'h5, 1, 8'hC5, 16'h0000);
    get_bytes(4'h5, 1, 0);
    $display("test reset_mid done");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_fill_stall();
    t_mask_wrap();
    t_modes();
    t_reset_mid();
    tally_and_finish();
  end

  // Watchdog: tests need a few thousand cycles at most
  initial begin
    #300000;
    fail_count++;
    tally_and_finish();
  end
endmodule // tb_center_aligned_read_strobe_port
